//--- pkg/acr_pkg.sv
// constants and types shared by the retry and compare-swap register block
package acr_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_RETRY = 12'h008;
    localparam logic [11:0] OFF_STORE = 12'h00C;
    localparam logic [11:0] OFF_COMPARE = 12'h010;
    localparam logic [11:0] OFF_CONTROL = 12'h014;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h030;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h034;
    // field layout
    localparam int RETRY_FIELD_W = 4;
    localparam int RETRY_USED_W = 12;
    localparam int DONE_BIT = 31;
    localparam int SEL_W = 2;
    localparam int NUM_UNITS = 3;
    localparam int NUM_RES = 4;
    localparam int IRQ_W = 4;
    // reset values
    localparam logic [11:0] RETRY_RST = 12'h000;
    localparam logic [31:0] STORE_RST = 32'h00000000;
    localparam logic [31:0] COMPARE_RST = 32'h00000000;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic DONE_RST = 1'b1;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    // resource select codes
    localparam logic [1:0] RES_BUS_MANAGER_ID = 2'h0;
    localparam logic [1:0] RES_BANDWIDTH_AVAILABLE = 2'h1;
    localparam logic [1:0] RES_CHANNELS_HI = 2'h2;
    localparam logic [1:0] RES_CHANNELS_LO = 2'h3;
    // transmit unit index
    localparam int UNIT_REQUEST = 0;
    localparam int UNIT_ASYNC_RESP = 1;
    localparam int UNIT_PHYS_RESP = 2;
    // ahb
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_WAIT_ACK = 2'b01
    } acr_retry_state_type;
endpackage : acr_pkg

//--- pkg/acr_retry_if.sv
// carrier between the register block and one transmit retry unit
`timescale 1ns/1ns
interface acr_retry_if;
    logic start;
    logic [3:0] limit;
    logic ack_valid;
    logic ack_retry;
    logic send;
    logic done;
    logic fail;

    modport unit (
        input start,
        input limit,
        input ack_valid,
        input ack_retry,
        output send,
        output done,
        output fail
    );
    modport ctrl (
        output start,
        output limit,
        output ack_valid,
        output ack_retry,
        input send,
        input done,
        input fail
    );
endinterface : acr_retry_if

//--- hdl/acr_retry_unit.sv
// retry counter for one asynchronous transmit unit
`timescale 1ns/1ns
module acr_retry_unit
    import acr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register side
    acr_retry_if.unit rif
);
    typedef struct packed {
        acr_retry_state_type state;
        logic [3:0] limit;
        logic [3:0] tries;
        logic send;
        logic done;
        logic fail;
    } acr_unit_state_type;

    acr_unit_state_type s_ff;
    acr_unit_state_type nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.send = 1'b0;
        nxt_s.done = 1'b0;
        nxt_s.fail = 1'b0;
        unique case (s_ff.state)
            ACR_IDLE: begin
                // limit is latched so a register rewrite cannot change a packet mid-flight
                if (rif.start) begin
                    nxt_s.limit = rif.limit;
                    nxt_s.tries = 4'h0;
                    nxt_s.send = 1'b1;
                    nxt_s.state = ACR_WAIT_ACK;
                end
            end
            ACR_WAIT_ACK: begin
                if (rif.ack_valid) begin
                    if (rif.ack_retry) begin
                        if (s_ff.tries < s_ff.limit) begin
                            nxt_s.tries = s_ff.tries + 4'h1;
                            nxt_s.send = 1'b1;
                        end else begin
                            nxt_s.fail = 1'b1;
                            nxt_s.state = ACR_IDLE;
                        end
                    end else begin
                        nxt_s.done = 1'b1;
                        nxt_s.state = ACR_IDLE;
                    end
                end
            end
            default: begin
                nxt_s.state = ACR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_ff <= '{state: ACR_IDLE, limit: 4'h0, tries: 4'h0,
                      send: 1'b0, done: 1'b0, fail: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rif.send = s_ff.send;
    assign rif.done = s_ff.done;
    assign rif.fail = s_ff.fail;

    property p_retry_on_busy;
        @(posedge clock) disable iff (rst)
        (s_ff.state == ACR_WAIT_ACK && rif.ack_valid && rif.ack_retry
         && s_ff.tries < s_ff.limit) |=> (rif.send && s_ff.tries == $past(s_ff.tries) + 4'h1);
    endproperty
    a_retry_on_busy: assert property (p_retry_on_busy) else $error("no resend on busy ack");

    property p_fail_at_limit;
        @(posedge clock) disable iff (rst)
        rif.fail |-> ($past(s_ff.tries) == $past(s_ff.limit) && !rif.send);
    endproperty
    a_fail_at_limit: assert property (p_fail_at_limit) else $error("gave up before limit");

    property p_no_retry_on_good_ack;
        @(posedge clock) disable iff (rst)
        (s_ff.state == ACR_WAIT_ACK && rif.ack_valid && !rif.ack_retry)
            |=> (rif.done && !rif.send && s_ff.state == ACR_IDLE);
    endproperty
    a_no_retry_on_good_ack: assert property (p_no_retry_on_good_ack) else $error("bad good ack");
endmodule : acr_retry_unit

//--- hdl/acr_regs.sv
// retry limit and compare-swap register block with AHB-Lite slave
`timescale 1ns/1ns
module acr_regs
    import acr_pkg::*;
#(
    parameter logic [31:0] RES0_RST = 32'h00000000,
    parameter logic [31:0] RES1_RST = 32'h00000000,
    parameter logic [31:0] RES2_RST = 32'h00000000,
    parameter logic [31:0] RES3_RST = 32'h00000000
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // transmit units: 0 request, 1 async response, 2 physical response
    input wire logic [2:0] tx_start,
    input wire logic [2:0] ack_valid,
    input wire logic [2:0] ack_retry,
    output logic [2:0] tx_send,
    output logic [2:0] tx_done,
    output logic [2:0] tx_fail,
    // bus-management resources, resource n at bits 32n+31..32n
    output logic [127:0] res_value,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic [11:0] retry;
        logic [31:0] store;
        logic [31:0] compare;
        logic [1:0] sel;
        logic done;
        logic busy;
        logic [3:0][31:0] res;
        logic [3:0] status;
        logic [3:0] mask;
        logic irq;
        logic [31:0] rdata;
        logic wr_pend;
        logic [11:0] wr_addr;
        logic rdy;
        logic err;
    } acr_regs_state_type;

    acr_regs_state_type s_ff;
    acr_regs_state_type nxt_s;

    logic accept;
    logic [2:0] unit_send;
    logic [2:0] unit_done;
    logic [2:0] unit_fail;
    logic [3:0] events;

    function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] off);
        is_reg = (addr == off);
    endfunction : is_reg

    // hsize is not decoded: only whole-word transfers are supported
    assign accept = hsel && hready && htrans[1];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
            acr_retry_if rif ();
            // field gi*4 holds the limit of unit gi
            assign rif.start = tx_start[gi];
            assign rif.limit = s_ff.retry[gi*RETRY_FIELD_W +: RETRY_FIELD_W];
            assign rif.ack_valid = ack_valid[gi];
            assign rif.ack_retry = ack_retry[gi];
            assign unit_send[gi] = rif.send;
            assign unit_done[gi] = rif.done;
            assign unit_fail[gi] = rif.fail;
            acr_retry_unit u_unit (
                .clock (clock),
                .rst (rst),
                .rif (rif.unit)
            );
        end
    endgenerate

    always_comb begin
        nxt_s = s_ff;
        events = {unit_fail, 1'b0};
        // register write lands in the data phase
        nxt_s.wr_pend = accept && hwrite;
        nxt_s.wr_addr = haddr[11:0];
        if (s_ff.wr_pend) begin
            if (is_reg(s_ff.wr_addr, OFF_RETRY)) begin
                nxt_s.retry = hwdata[RETRY_USED_W-1:0];
            end
            if (is_reg(s_ff.wr_addr, OFF_STORE)) begin
                nxt_s.store = hwdata;
            end
            if (is_reg(s_ff.wr_addr, OFF_COMPARE)) begin
                nxt_s.compare = hwdata;
            end
            if (is_reg(s_ff.wr_addr, OFF_CONTROL)) begin
                nxt_s.done = 1'b0;
                // a write while a swap is in flight has no effect: completion sets the flag again
                if (!s_ff.busy) begin
                    nxt_s.sel = hwdata[SEL_W-1:0];
                    nxt_s.busy = 1'b1;
                end
            end
            if (is_reg(s_ff.wr_addr, OFF_IRQ_STATUS)) begin
                nxt_s.status = s_ff.status & ~hwdata[IRQ_W-1:0];
            end
            if (is_reg(s_ff.wr_addr, OFF_IRQ_MASK)) begin
                nxt_s.mask = hwdata[IRQ_W-1:0];
            end
        end
        // swap takes one cycle; completion set wins over a clearing write
        if (s_ff.busy) begin
            if (s_ff.res[s_ff.sel] == s_ff.compare) begin
                nxt_s.res[s_ff.sel] = s_ff.store;
            end
            nxt_s.done = 1'b1;
            nxt_s.busy = 1'b0;
            events[0] = 1'b1;
        end
        nxt_s.status = nxt_s.status | events;
        nxt_s.irq = |(nxt_s.status & nxt_s.mask);
        // read data is captured in the address phase so there are no wait states
        nxt_s.rdata = 32'h00000000;
        if (accept && !hwrite) begin
            if (is_reg(haddr[11:0], OFF_RETRY)) begin
                nxt_s.rdata = {20'h00000, s_ff.retry};
            end
            if (is_reg(haddr[11:0], OFF_STORE)) begin
                nxt_s.rdata = s_ff.store;
            end
            if (is_reg(haddr[11:0], OFF_COMPARE)) begin
                nxt_s.rdata = s_ff.compare;
            end
            if (is_reg(haddr[11:0], OFF_CONTROL)) begin
                nxt_s.rdata = {s_ff.done, 29'h00000000, s_ff.sel};
            end
            if (is_reg(haddr[11:0], OFF_IRQ_STATUS)) begin
                nxt_s.rdata = {28'h0000000, s_ff.status};
            end
            if (is_reg(haddr[11:0], OFF_IRQ_MASK)) begin
                nxt_s.rdata = {28'h0000000, s_ff.mask};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_ff.retry <= RETRY_RST;
            s_ff.store <= STORE_RST;
            s_ff.compare <= COMPARE_RST;
            s_ff.sel <= SEL_RST;
            s_ff.done <= DONE_RST;
            s_ff.busy <= 1'b0;
            s_ff.res <= {RES3_RST, RES2_RST, RES1_RST, RES0_RST};
            s_ff.status <= 4'h0;
            s_ff.mask <= IRQ_MASK_RST;
            s_ff.irq <= 1'b0;
            s_ff.rdata <= 32'h00000000;
            s_ff.wr_pend <= 1'b0;
            s_ff.wr_addr <= 12'h000;
            s_ff.rdy <= 1'b1;
            s_ff.err <= 1'b0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // slave never stalls and always answers okay
    assign hreadyout = s_ff.rdy;
    assign hresp = s_ff.err;
    assign hrdata = s_ff.rdata;
    assign tx_send = unit_send;
    assign tx_done = unit_done;
    assign tx_fail = unit_fail;
    assign res_value = s_ff.res;
    assign irq = s_ff.irq;

    property p_retry_top_zero;
        @(posedge clock) disable iff (rst)
        (accept && !hwrite && haddr[11:0] == OFF_RETRY) |=> hrdata[31:29] == 3'h0;
    endproperty
    a_retry_top_zero: assert property (p_retry_top_zero) else $error("second bound nonzero");

    property p_retry_cycle_zero;
        @(posedge clock) disable iff (rst)
        (accept && !hwrite && haddr[11:0] == OFF_RETRY) |=> hrdata[28:16] == 13'h0000;
    endproperty
    a_retry_cycle_zero: assert property (p_retry_cycle_zero) else $error("cycle bound nonzero");

    property p_retry_gap_zero;
        @(posedge clock) disable iff (rst)
        (accept && !hwrite && haddr[11:0] == OFF_RETRY)
            |=> (hrdata[15:12] == 4'h0 && hrdata[11:0] == $past(s_ff.retry));
    endproperty
    a_retry_gap_zero: assert property (p_retry_gap_zero) else $error("retry readback bad");

    property p_limit_routed;
        @(posedge clock) disable iff (rst)
        s_ff.wr_pend && s_ff.wr_addr == OFF_RETRY |=> g_unit[2].rif.limit == $past(hwdata[11:8]);
    endproperty
    a_limit_routed: assert property (p_limit_routed) else $error("phys limit not routed");

    property p_swap_match;
        @(posedge clock) disable iff (rst)
        (s_ff.busy && s_ff.res[s_ff.sel] == s_ff.compare)
            |=> (s_ff.res[$past(s_ff.sel)] == $past(s_ff.store) && s_ff.done);
    endproperty
    a_swap_match: assert property (p_swap_match) else $error("swap did not store");

    property p_swap_miss;
        @(posedge clock) disable iff (rst)
        (s_ff.busy && s_ff.res[s_ff.sel] != s_ff.compare)
            |=> (s_ff.res == $past(s_ff.res) && s_ff.done);
    endproperty
    a_swap_miss: assert property (p_swap_miss) else $error("failed compare changed resource");

    property p_done_after_launch;
        @(posedge clock) disable iff (rst)
        (s_ff.wr_pend && s_ff.wr_addr == OFF_CONTROL && !s_ff.busy)
            |=> (!s_ff.done && s_ff.busy) ##1 s_ff.done;
    endproperty
    a_done_after_launch: assert property (p_done_after_launch) else $error("done timing");

    property p_write_clears;
        @(posedge clock) disable iff (rst)
        (s_ff.wr_pend && s_ff.wr_addr == OFF_CONTROL && !s_ff.busy) |=> !s_ff.done;
    endproperty
    a_write_clears: assert property (p_write_clears) else $error("control write kept done");

    property p_control_zero;
        @(posedge clock) disable iff (rst)
        (accept && !hwrite && haddr[11:0] == OFF_CONTROL)
            |=> (hrdata[30:2] == 29'h00000000 && hrdata[31] == $past(s_ff.done));
    endproperty
    a_control_zero: assert property (p_control_zero) else $error("control reserved bits set");

    property p_done_after_reset;
        @(posedge clock)
        $past(rst) && !rst |-> s_ff.done;
    endproperty
    a_done_after_reset: assert property (p_done_after_reset) else $error("done low after reset");

    property p_irq_follows;
        @(posedge clock) disable iff (rst)
        s_ff.busy |=> (s_ff.status[0] && irq == |(s_ff.status & s_ff.mask));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq out of step");

    property p_resp_limit;
        @(posedge clock) disable iff (rst)
        (s_ff.wr_pend && s_ff.wr_addr == OFF_RETRY)
            |=> g_unit[1].rif.limit == $past(hwdata[7:4]);
    endproperty
    a_resp_limit: assert property (p_resp_limit) else $error("resp limit not routed");

    property p_req_limit;
        @(posedge clock) disable iff (rst)
        (s_ff.wr_pend && s_ff.wr_addr == OFF_RETRY)
            |=> g_unit[0].rif.limit == $past(hwdata[3:0]);
    endproperty
    a_req_limit: assert property (p_req_limit) else $error("req limit not routed");

    property p_store_loaded;
        @(posedge clock) disable iff (rst)
        (s_ff.wr_pend && s_ff.wr_addr == OFF_STORE) |=> s_ff.store == $past(hwdata);
    endproperty
    a_store_loaded: assert property (p_store_loaded) else $error("store not loaded");

    property p_compare_loaded;
        @(posedge clock) disable iff (rst)
        (s_ff.wr_pend && s_ff.wr_addr == OFF_COMPARE) |=> s_ff.compare == $past(hwdata);
    endproperty
    a_compare_loaded: assert property (p_compare_loaded) else $error("compare not loaded");

    property p_sel_loaded;
        @(posedge clock) disable iff (rst)
        (s_ff.wr_pend && s_ff.wr_addr == OFF_CONTROL && !s_ff.busy)
            |=> s_ff.sel == $past(hwdata[1:0]);
    endproperty
    a_sel_loaded: assert property (p_sel_loaded) else $error("select not loaded");

    property p_sel_read;
        @(posedge clock) disable iff (rst)
        (accept && !hwrite && haddr[11:0] == OFF_CONTROL)
            |=> hrdata[1:0] == $past(s_ff.sel);
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select readback bad");

    property p_swap_one_cycle;
        @(posedge clock) disable iff (rst)
        s_ff.busy |=> !s_ff.busy;
    endproperty
    a_swap_one_cycle: assert property (p_swap_one_cycle) else $error("swap overran");

    property p_done_source;
        @(posedge clock) disable iff (rst)
        $rose(s_ff.done) |-> $past(s_ff.busy);
    endproperty
    a_done_source: assert property (p_done_source) else $error("done without swap");

    property p_res_hold;
        @(posedge clock) disable iff (rst)
        !s_ff.busy |=> s_ff.res == $past(s_ff.res);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("resource changed idle");

    property p_status_clear;
        @(posedge clock) disable iff (rst)
        (s_ff.wr_pend && s_ff.wr_addr == OFF_IRQ_STATUS && !s_ff.busy && unit_fail == 3'h0)
            |=> s_ff.status == ($past(s_ff.status) & ~$past(hwdata[3:0]));
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status clear bad");

    property p_fail_status;
        @(posedge clock) disable iff (rst)
        unit_fail != 3'h0 |=> (s_ff.status[3:1] & $past(unit_fail)) == $past(unit_fail);
    endproperty
    a_fail_status: assert property (p_fail_status) else $error("fail not flagged");

    property p_rdata_idle;
        @(posedge clock) disable iff (rst)
        !(accept && !hwrite) |=> hrdata == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data held");

    property p_bus_okay;
        @(posedge clock) disable iff (rst)
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("slave stalled or erred");
endmodule : acr_regs

//--- verif/acr_remote_node.sv
// remote bus nodes: acknowledge each packet, busy for a set number of tries
`timescale 1ns/1ns
module acr_remote_node (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link side
    input wire logic [2:0] tx_send,
    output logic [2:0] ack_valid,
    output logic [2:0] ack_retry,
    // bench control
    input wire logic [2:0] busy_load,
    input wire logic [3:0] busy_num,
    input wire logic [2:0] ack_delay
);
    logic [3:0] left_ff [3];
    logic [2:0] wait_ff [3];
    logic [2:0] pend_ff;
    logic tog_ff;

    always_ff @(posedge clock) begin
        tog_ff <= rst ? 1'b0 : ~tog_ff;
        for (int i = 0; i < 3; i++) begin
            ack_valid[i] <= 1'b0;
            // the qualifier means nothing outside a pulse, so it never holds a stale value
            ack_retry[i] <= tog_ff;
            if (busy_load[i]) begin
                left_ff[i] <= busy_num;
            end
            if (rst) begin
                pend_ff[i] <= 1'b0;
            end else if (tx_send[i]) begin
                pend_ff[i] <= 1'b1;
                wait_ff[i] <= ack_delay;
            end else if (pend_ff[i] && wait_ff[i] == 3'h0) begin
                pend_ff[i] <= 1'b0;
                ack_valid[i] <= 1'b1;
                ack_retry[i] <= (left_ff[i] != 4'h0);
                if (left_ff[i] != 4'h0) begin
                    left_ff[i] <= left_ff[i] - 4'h1;
                end
            end else if (pend_ff[i]) begin
                wait_ff[i] <= wait_ff[i] - 3'h1;
            end
        end
    end
endmodule : acr_remote_node

//--- verif/tb.sv
// self-checking bench for the retry and compare-swap register block
`timescale 1ns/1ns
module tb;
    import acr_pkg::*;
    localparam logic [31:0] RES_INIT [4] = '{32'h0000003F, 32'h00001333, 32'hFFFFFFFF, 32'hFFFF0000};
    logic clock, rst, hsel, hwrite, hreadyout, hresp, irq, rdy_smp;
    logic [31:0] haddr, hwdata, hrdata, rd_smp;
    logic [1:0] htrans;
    logic [2:0] hsize, tx_start, ack_valid, ack_retry, tx_send, tx_done, tx_fail;
    logic [2:0] busy_load, ack_delay, done_seen, fail_seen;
    logic [3:0] busy_num;
    logic [127:0] res_value;
    logic [31:0] res_exp [4];
    int n_fail, tests_run, sends [3];

    acr_regs #(.RES0_RST(RES_INIT[0]), .RES1_RST(RES_INIT[1]), .RES2_RST(RES_INIT[2]),
        .RES3_RST(RES_INIT[3])) dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_start(tx_start),
        .ack_valid(ack_valid), .ack_retry(ack_retry), .tx_send(tx_send), .tx_done(tx_done),
        .tx_fail(tx_fail), .res_value(res_value), .irq(irq));
    acr_remote_node node (.clock(clock), .rst(rst), .tx_send(tx_send), .ack_valid(ack_valid),
        .ack_retry(ack_retry), .busy_load(busy_load), .busy_num(busy_num),
        .ack_delay(ack_delay));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // edge-sampled copies, so the tasks never race the design's own updates
    always @(posedge clock) begin
        rd_smp <= hrdata;
        rdy_smp <= hreadyout;
        for (int i = 0; i < 3; i++) begin
            if (tx_send[i]) sends[i] <= sends[i] + 1;
            if (tx_done[i]) done_seen[i] <= 1'b1;
            if (tx_fail[i]) fail_seen[i] <= 1'b1;
        end
    end

    task tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [31:0] exp_sends(input logic [3:0] lim, input logic [3:0] busy);
        exp_sends = ((busy > lim) ? 32'(lim) : 32'(busy)) + 32'h1;
    endfunction : exp_sends

    function automatic logic [31:0] exp_fail(input logic [3:0] lim, input logic [3:0] busy);
        exp_fail = {31'h0, busy > lim};
    endfunction : exp_fail

    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        for (n = 0; n < 2; n++) begin
            do begin @(posedge clock); #1; end while (rdy_smp !== 1'b1);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
        end
        rd = rd_smp;
    endtask : ahb

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr

    task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(name, exp, x);
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : rd_chk

    task swap(input logic [1:0] sel, input logic hit);
        logic [31:0] cmp, st, cw, x;
        int n;
        st = $urandom();
        cw = $urandom();
        cw[1:0] = sel;
        cmp = hit ? res_exp[sel] : res_exp[sel] ^ ($urandom() | 32'h1);
        wr(OFF_STORE, st);
        wr(OFF_COMPARE, cmp);
        rd_chk("store", OFF_STORE, st);
        wr(OFF_CONTROL, cw);
        n = 0;
        do begin ahb(1'b0, OFF_CONTROL, 32'h0, x); n++; end while (x[DONE_BIT] !== 1'b1 && n < 16);
        if (hit) res_exp[sel] = st;
        check("control", {1'b1, 29'h0, sel}, x);
        check("resource", res_exp[sel], res_value[32*sel +: 32]);
    endtask : swap

    task retry(input int u, input logic [3:0] lim, input logic [3:0] busy);
        logic [31:0] x;
        int n;
        x = $urandom();
        x[4*u +: 4] = lim;
        wr(OFF_RETRY, x);
        rd_chk("retry", OFF_RETRY, x & 32'h00000FFF);
        sends[u] = 0;
        done_seen[u] = 1'b0;
        fail_seen[u] = 1'b0;
        @(posedge clock);
        busy_num <= busy;
        busy_load[u] <= 1'b1;
        ack_delay <= 3'($urandom_range(7, 0));
        tx_start[u] <= 1'b1;
        @(posedge clock);
        busy_load <= 3'h0;
        tx_start <= 3'h0;
        n = 0;
        while (done_seen[u] !== 1'b1 && fail_seen[u] !== 1'b1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("retry wait", 32'h1, {31'h0, n < 400});
        check("sends", exp_sends(lim, busy), 32'(sends[u]));
        check("fail", exp_fail(lim, busy), {31'h0, fail_seen[u]});
        rd_chk("status", OFF_IRQ_STATUS, exp_fail(lim, busy) << (u + 1));
        wr(OFF_IRQ_STATUS, 32'h0000000F);
    endtask : retry

    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        tx_start = 3'h0;
        busy_load = 3'h0;
        busy_num = 4'h0;
        ack_delay = 3'h0;
        rst = 1'b1;
        n_fail = 0;
        tests_run = 0;
        res_exp = RES_INIT;
        void'($urandom(32'h3d1a));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rd_chk("retry", OFF_RETRY, 32'h0);
        rd_chk("control", OFF_CONTROL, 32'h80000000);
        rd_chk("compare", OFF_COMPARE, COMPARE_RST);
        rd_chk("mask", OFF_IRQ_MASK, 32'h0);
        rd_chk("unmapped", 12'h040, 32'h0);
        // limit 0 with a busy answer, then the full limit of 15, then random
        for (int k = 0; k < 12; k++) begin
            retry(k % 3, (k < 3) ? 4'h0 : (k < 6) ? 4'hF : 4'($urandom()),
                (k < 3) ? 4'h1 : (k < 6) ? 4'hF : 4'($urandom()));
        end
        wr(OFF_IRQ_MASK, 32'h1);
        for (int k = 0; k < 12; k++) begin
            swap(2'(k), (k < 4) ? 1'b1 : (k < 8) ? 1'b0 : 1'($urandom()));
            check("irq", 32'h1, {31'h0, irq});
            wr(OFF_IRQ_STATUS, 32'h1);
            repeat (2) @(posedge clock);
            #1;
            check("irq", 32'h0, {31'h0, irq});
        end
        wr(OFF_IRQ_MASK, 32'h0);
        swap(2'h2, 1'b1);
        check("irq", 32'h0, {31'h0, irq});
        rd_chk("status", OFF_IRQ_STATUS, 32'h1);
        tally_and_finish();
    end

    // the whole run needs well under this many cycles
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        tally_and_finish();
    end
endmodule : tb
